// ### hw/dbas_pkg.sv
// package for the data bank address select block
package dbas_pkg;

    // ****************************************************************
    // address layout
    // ****************************************************************
    localparam int DBAS_ADDR_W = 12;
    localparam int DBAS_OPND_W = 8;
    localparam int DBAS_BANK_W = 4;
    localparam int DBAS_DATA_W = 8;
    localparam int DBAS_NUM_BANKS = 16;
    // access window split: operands below this come from bank 0
    localparam logic [7:0] DBAS_ACC_LOW_LIMIT = 8'h60;
    localparam logic [3:0] DBAS_ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] DBAS_ACC_HIGH_BANK = 4'hf;
    localparam logic [7:0] DBAS_BANK_SEL_RESET = 8'h00;
    localparam logic [7:0] DBAS_BANK_SEL_MASK = 8'h0f;
    // default: every bank implemented
    localparam logic [15:0] DBAS_BANK_IMPL_DEFAULT = 16'hffff;

    // ****************************************************************
    // request carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic access_sel;
        logic [7:0] operand;
        logic [7:0] wdata;
    } dbas_direct_req_type;

    typedef struct packed {
        logic valid;
        logic [11:0] src_addr;
        logic [11:0] dst_addr;
    } dbas_move_req_type;

endpackage

// ### hw/dbas_top.sv
// data bank address select: direct addressing into banked data ram
//
// Operation
// - window: bank0 low 96, bank15 high 160
// - access-select bit picks bank or window
// - with select 0, low region abuts high
// - high region reaches special registers without banking
// - sixteen banks; bank_select low nibble gives upper
// - bank_select upper nibble reads zero, ignores writes
// - unimplemented bank reads zero, drops writes
// - status flags still update from zero read
// - each bank 256 bytes, operand 00h-ffh
// - full address move ignores bank_select
// - literal to bank load writes bank_select
// - all data memory is static storage
`timescale 1ns/1ps

module dbas_top
    import dbas_pkg::*;
#(
    parameter logic [15:0] BANK_IMPL = DBAS_BANK_IMPL_DEFAULT
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // direct access from the decoder
    input wire dbas_direct_req_type i_direct,
    // full address move from the decoder
    input wire dbas_move_req_type i_move,
    // literal to bank load
    input wire logic i_literal_to_bank_load,
    input wire logic [7:0] i_bank_literal,
    // bank_select register write as a data target
    input wire logic i_bank_sel_wr,
    input wire logic [7:0] i_bank_sel_wdata,
    // read results toward the alu
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic [11:0] o_rd_addr,
    output logic o_move_done,
    // bank_select readback
    output logic [7:0] o_bank_select
);

    // ****************************************************************
    // bank select register
    // ****************************************************************
    logic [3:0] bank_sel_r;
    logic [3:0] bank_sel_nxt;

    always_comb begin
        bank_sel_nxt = bank_sel_r;
        if (i_literal_to_bank_load) begin
            // upper nibble dropped
            bank_sel_nxt = i_bank_literal[3:0];
        end else if (i_bank_sel_wr) begin
            bank_sel_nxt = i_bank_sel_wdata[3:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bank_sel_r <= DBAS_BANK_SEL_RESET[3:0];
        end else begin
            bank_sel_r <= bank_sel_nxt;
        end
    end

    // upper nibble always reads zero
    assign o_bank_select = {4'h0, bank_sel_r} & DBAS_BANK_SEL_MASK;

    // ****************************************************************
    // direct address formation
    // ****************************************************************
    logic [11:0] direct_addr;

    always_comb begin
        if (i_direct.access_sel) begin
            direct_addr = {bank_sel_r, i_direct.operand};
        end else if (i_direct.operand < DBAS_ACC_LOW_LIMIT) begin
            direct_addr = {DBAS_ACC_LOW_BANK, i_direct.operand};
        end else begin
            // special registers without banking
            direct_addr = {DBAS_ACC_HIGH_BANK, i_direct.operand};
        end
    end

    // ****************************************************************
    // static data memory
    // ****************************************************************
    // plain flip-flop array; holds contents while clocked
    logic [7:0] mem_r [0:DBAS_NUM_BANKS*256-1];

    function automatic logic bank_ok(input logic [11:0] a);
        return BANK_IMPL[a[11:8]];
    endfunction

    // move has priority: it holds the decoder for its own cycle
    logic mem_we;
    logic [11:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [11:0] rd_addr;
    logic [7:0] rd_data;

    always_comb begin
        mem_we = 1'b0;
        mem_waddr = 12'h000;
        mem_wdata = 8'h00;
        rd_addr = direct_addr;
        if (i_move.valid) begin
            rd_addr = i_move.src_addr;
            mem_waddr = i_move.dst_addr;
            mem_wdata = bank_ok(i_move.src_addr) ?
                        mem_r[i_move.src_addr] : 8'h00;
            mem_we = bank_ok(i_move.dst_addr);
        end else if (i_direct.valid && i_direct.write) begin
            mem_waddr = direct_addr;
            mem_wdata = i_direct.wdata;
            mem_we = bank_ok(direct_addr);
        end
        // zero from an empty bank still reaches the alu
        rd_data = bank_ok(rd_addr) ? mem_r[rd_addr] : 8'h00;
    end

    always_ff @(posedge i_sys_clk) begin
        if (mem_we) begin
            mem_r[mem_waddr] <= mem_wdata;
        end
    end

    // ****************************************************************
    // registered read answer
    // ****************************************************************
    logic rd_valid_r;
    logic rd_valid_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic [11:0] rd_addr_r;
    logic [11:0] rd_addr_nxt;
    logic move_done_r;
    logic move_done_nxt;

    always_comb begin
        rd_valid_nxt = i_direct.valid && !i_direct.write && !i_move.valid;
        move_done_nxt = i_move.valid;
        rd_data_nxt = rd_data_r;
        rd_addr_nxt = rd_addr_r;
        if (rd_valid_nxt || move_done_nxt) begin
            rd_data_nxt = rd_data;
            rd_addr_nxt = rd_addr;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
            rd_addr_r <= 12'h000;
            move_done_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_valid_nxt;
            rd_data_r <= rd_data_nxt;
            rd_addr_r <= rd_addr_nxt;
            move_done_r <= move_done_nxt;
        end
    end

    assign o_rd_valid = rd_valid_r;
    assign o_rd_data = rd_data_r;
    assign o_rd_addr = rd_addr_r;
    assign o_move_done = move_done_r;

endmodule

// ### tb/dbas_checker.sv
// port assertions for dbas_top
`timescale 1ns/1ps
module dbas_checker
    import dbas_pkg::*;
(
    // inputs
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire dbas_direct_req_type i_direct,
    input wire dbas_move_req_type i_move,
    input wire logic i_literal_to_bank_load,
    input wire logic [7:0] i_bank_literal,
    input wire logic i_bank_sel_wr,
    input wire logic [7:0] i_bank_sel_wdata,
    // outputs
    input wire logic o_rd_valid,
    input wire logic [7:0] o_rd_data,
    input wire logic [11:0] o_rd_addr,
    input wire logic o_move_done,
    input wire logic [7:0] o_bank_select
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // a move steals the cycle, so only an unshadowed read counts
    wire logic rd = i_direct.valid && !i_direct.write && !i_move.valid;
    wire logic win = rd && !i_direct.access_sel;
    chk_bank_upper: assert property (o_bank_select[7:4] == 4'h0)
        else $error("bank upper nibble set");
    chk_rd_answer: assert property (rd |=> o_rd_valid)
        else $error("read not answered");
    chk_rd_quiet: assert property (!rd |=> !o_rd_valid)
        else $error("spurious read answer");
    chk_win_low: assert property (win && i_direct.operand < 8'h60
        |=> o_rd_addr == {4'h0, $past(i_direct.operand)}) else $error("low");
    chk_win_high: assert property (win && i_direct.operand >= 8'h60
        |=> o_rd_addr == {4'hf, $past(i_direct.operand)}) else $error("high");
    chk_bank_addr: assert property (rd && i_direct.access_sel
        |=> o_rd_addr == {$past(o_bank_select[3:0]), $past(i_direct.operand)})
        else $error("banked address wrong");
    chk_bank_load: assert property (i_literal_to_bank_load
        |=> o_bank_select == {4'h0, $past(i_bank_literal[3:0])})
        else $error("bank load wrong");
    chk_move_src: assert property (i_move.valid
        |=> o_move_done && o_rd_addr == $past(i_move.src_addr))
        else $error("move wrong");
    cover property (win);
    cover property (i_move.valid);
    cover property (i_bank_sel_wr);
endmodule
bind dbas_top dbas_checker dbas_checker_inst (.*);

// ### tb/dbas_dec_model.sv
// decoder model: one request per call, released lines show inverse data
`timescale 1ns/1ps
module dbas_dec_model
    import dbas_pkg::*;
(
    input wire logic i_sys_clk,
    output dbas_direct_req_type o_direct,
    output dbas_move_req_type o_move,
    output logic o_load,
    output logic o_bsw,
    output logic [7:0] o_lit
);
    initial {o_direct, o_move, o_load, o_bsw, o_lit} = '0;
    task automatic req(input dbas_direct_req_type d,
        input dbas_move_req_type m, input logic l, b, input logic [7:0] v);
        @(posedge i_sys_clk);
        {o_direct, o_move, o_load, o_bsw, o_lit} <= {d, m, l, b, v};
        @(posedge i_sys_clk);
        {o_direct, o_move, o_load, o_bsw, o_lit} <=
            {1'b0, ~d[17:0], 1'b0, ~m[23:0], 2'b00, ~v};
        #1;
    endtask
endmodule

// ### tb/tb.sv
// self-checking bench for dbas_top
`timescale 1ns/1ps
module tb;
    import dbas_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    dbas_direct_req_type dr;
    dbas_move_req_type mr;
    logic ld, bw, rv, md;
    logic [7:0] lit, rd, bs;
    logic [11:0] ra;
    int err_count = 0;
    int checked = 0;
    dbas_dec_model dbas_dec_model_inst (.i_sys_clk(i_sys_clk), .o_direct(dr),
        .o_move(mr), .o_load(ld), .o_bsw(bw), .o_lit(lit));
    // bank 2 left unimplemented
    dbas_top #(.BANK_IMPL(16'hfffb)) dbas_top_inst (.i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn), .i_direct(dr), .i_move(mr),
        .i_literal_to_bank_load(ld), .i_bank_literal(lit), .i_bank_sel_wr(bw),
        .i_bank_sel_wdata(lit), .o_rd_valid(rv), .o_rd_data(rd),
        .o_rd_addr(ra), .o_move_done(md), .o_bank_select(bs));
    initial forever #5 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [12:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic w, a, input logic [7:0] op, d);
        dbas_dec_model_inst.req({1'b1, w, a, op, d}, '0, 1'b0, 1'b0, 8'h00);
    endtask
    task automatic bsel(input logic l, b, input logic [7:0] v);
        dbas_dec_model_inst.req('0, '0, l, b, v);
        chk({5'h00, bs}, {9'h000, v[3:0]});
    endtask
    task automatic rdc(input logic a, input logic [7:0] op,
        input logic [11:0] ea, input logic [7:0] ed);
        acc(1'b0, a, op, 8'h00);
        chk({rv, ra}, {1'b1, ea});
        chk({5'h00, rd}, {5'h00, ed});
    endtask
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        #1 chk({5'h00, bs}, 13'h0000);
        bsel(1'b1, 1'b0, 8'hf3);
        acc(1'b1, 1'b1, 8'hff, 8'ha5);
        rdc(1'b1, 8'hff, 12'h3ff, 8'ha5);
        acc(1'b1, 1'b0, 8'h5f, 8'h11);
        acc(1'b1, 1'b0, 8'h60, 8'h22);
        rdc(1'b0, 8'h5f, 12'h05f, 8'h11);
        rdc(1'b0, 8'h60, 12'hf60, 8'h22);
        bsel(1'b0, 1'b1, 8'hff);
        rdc(1'b1, 8'h60, 12'hf60, 8'h22);
        $display("test window done");
        dbas_dec_model_inst.req('0, {1'b1, 12'hf60, 12'h105}, 1'b0, 1'b0, 8'h00);
        chk({md, ra}, {1'b1, 12'hf60});
        chk({5'h00, rd}, {5'h00, 8'h22});
        dbas_dec_model_inst.req({1'b1, 1'b0, 1'b1, 8'h05, 8'h00},
            {1'b1, 12'h105, 12'h205}, 1'b0, 1'b0, 8'h00);
        chk({11'h000, rv, md}, 13'h0001);
        chk({1'b0, ra}, {1'b0, 12'h105});
        bsel(1'b1, 1'b0, 8'h01);
        rdc(1'b1, 8'h05, 12'h105, 8'h22);
        bsel(1'b1, 1'b0, 8'h02);
        acc(1'b1, 1'b1, 8'h05, 8'h77);
        rdc(1'b1, 8'h05, 12'h205, 8'h00);
        $display("test banks done");
        finish_test();
    end
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
endmodule
